// ---- src/ptls_cfg.svh ----
`ifndef PTLS_CFG_SVH
`define PTLS_CFG_SVH

// ************************
// Register map (byte addr)
// ************************
`define PTLS_ADDR_W 8
`define PTLS_ADDR_CTRL 8'h00
`define PTLS_ADDR_AOSEL 8'h04
`define PTLS_ADDR_BAL 8'h08
`define PTLS_ADDR_STAT 8'h0c

// ************************
// Control register fields
// ************************
`define PTLS_CTRL_W 7
`define PTLS_CTRL_LOADWATCH 0
`define PTLS_CTRL_SCANOFF 1
`define PTLS_CTRL_FORCE 2
`define PTLS_CTRL_INTDIS 3
`define PTLS_CTRL_EXTDIS 4
`define PTLS_CTRL_CHG 5
`define PTLS_CTRL_DSG 6
`define PTLS_CTRL_RESET 7'h00

// ************************
// Status register fields
// ************************
`define PTLS_STAT_LOAD 0
`define PTLS_STAT_INTOT 1
`define PTLS_STAT_EXTOT 2
`define PTLS_STAT_SUPPLY 3
`define PTLS_STAT_SHUT 4
`define PTLS_STAT_EXTHOT 5
`define PTLS_STAT_INTHOT 6

// ************************
// Analog select codes
// ************************
`define PTLS_AO_W 4
`define PTLS_AO_RESET 4'h0
`define PTLS_AO_EXT_TEMP 4'h8
`define PTLS_AO_INT_TEMP 4'h9

// ************************
// Pin synchroniser slots
// ************************
`define PTLS_PIN_LOAD 0
`define PTLS_PIN_THERM 1
`define PTLS_PIN_IHOT 2

// ************************
// Timing
// ************************
`define PTLS_CLK_PERIOD_NS 5
`define PTLS_TICK_NS 1000000
`define PTLS_TICK_CYCLES (`PTLS_TICK_NS / `PTLS_CLK_PERIOD_NS)
`define PTLS_SCAN_PERIOD_MS 640
`define PTLS_SCAN_ON_MS 5
`define PTLS_SETTLE_MS 1
`define PTLS_CELLS 6

`endif

// ---- src/ptls_pkg.sv ----
`default_nettype none
package ptls_pkg;
    // Data phase held by the bus slave
    typedef enum logic [1:0] {
        PTLS_PH_IDLE,
        PTLS_PH_READ,
        PTLS_PH_WRITE
    } ptls_phase_type;

    // Requesters of the sensor supply that run a settle and compare
    typedef enum logic [1:0] {
        PTLS_SRC_AUTO,
        PTLS_SRC_HOST,
        PTLS_SRC_FORCE
    } ptls_src_type;
endpackage
`default_nettype wire

// ---- src/ptls_scan_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "ptls_cfg.svh"
module ptls_scan_timer
    import ptls_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `PTLS_TICK_CYCLES,
    parameter int unsigned PERIOD_TICKS = `PTLS_SCAN_PERIOD_MS,
    parameter int unsigned ON_TICKS = `PTLS_SCAN_ON_MS
) (
    // Clock and synchronised reset
    input wire logic clk,
    input wire logic rstSyncB,
    // Timing outputs
    output logic msTick,
    output logic scanWindow
);
    localparam int DIV_W = $clog2(TICK_CYCLES);
    localparam int MS_W = $clog2(PERIOD_TICKS);

    typedef struct packed {
        logic [DIV_W-1:0] divCnt;
        logic [MS_W-1:0] msCnt;
        logic tick;
        logic window;
    } ptls_timer_state_type;

    ptls_timer_state_type state;
    ptls_timer_state_type next_state;

    // ************************
    // Millisecond divider and scan period
    // ************************
    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (state.divCnt == DIV_W'(TICK_CYCLES - 1)) begin
            next_state.divCnt = '0;
            next_state.tick = 1'b1;
            if (state.msCnt == MS_W'(PERIOD_TICKS - 1)) begin
                next_state.msCnt = '0;
            end else begin
                next_state.msCnt = state.msCnt + MS_W'(1);
            end
        end else begin
            next_state.divCnt = state.divCnt + DIV_W'(1);
        end
        next_state.window = (next_state.msCnt < MS_W'(ON_TICKS));
    end

    // Counters restart at reset so the first pulse starts right away
    always_ff @(posedge clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            state <= '{divCnt: '0, msCnt: '0, tick: 1'b0,
                       window: 1'b1};
        end else begin
            state <= next_state;
        end
    end

    assign msTick = state.tick;
    assign scanWindow = state.window;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSyncB);

    scan_window_a: assert property (
        scanWindow == (state.msCnt < MS_W'(ON_TICKS)))
        else $error("scan window does not match period count");
endmodule
`default_nettype wire

// ---- src/ptls_top.sv ----
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ptls_cfg.svh"
module ptls_top
    import ptls_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `PTLS_TICK_CYCLES,
    parameter int unsigned CELLS = `PTLS_CELLS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Comparator pins from the analog front end
    input wire logic loadSenseHigh,
    input wire logic thermistorBelowRef,
    input wire logic internalHot,
    // Overcurrent flags from the protection logic
    input wire logic chargeOvercurrentFlag,
    input wire logic dischargeOvercurrentFlag,
    input wire logic shortCircuitFlag,
    // Switch and monitor controls
    output logic loadWatchEnable,
    output logic thermistorSupplyOut,
    output logic chargeSwitchCtrl,
    output logic dischargeSwitchCtrl,
    output logic [CELLS-1:0] balanceSwitch,
    output logic [`PTLS_AO_W-1:0] analogOutSelect,
    // Status
    output logic loadStillPresentFlag,
    output logic internalOvertempFlag,
    output logic externalOvertempFlag
);
    localparam int unsigned SETTLE_CYCLES = `PTLS_SETTLE_MS * TICK_CYCLES;
    localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
    localparam int NSRC = 3;

    typedef struct packed {
        logic [2:0] syncA;
        logic [2:0] syncB;
        logic [`PTLS_CTRL_W-1:0] ctrl;
        logic [`PTLS_AO_W-1:0] aoSel;
        logic [CELLS-1:0] balance;
        logic loadFlag;
        logic intFlag;
        logic extFlag;
        logic extHot;
        logic [NSRC-1:0][SETTLE_W-1:0] settle;
        logic supply;
        logic chargeOut;
        logic dischargeOut;
        logic [CELLS-1:0] balanceOut;
        ptls_phase_type phase;
        logic [`PTLS_ADDR_W-1:0] addr;
        logic [31:0] rdata;
    } ptls_top_state_type;

    ptls_top_state_type state;
    ptls_top_state_type next_state;

    // ************************
    // Reset release
    // ************************
    logic [1:0] rstPipe;
    logic rstSyncB;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSyncB = rstPipe[1];

    // ************************
    // Scan timing
    // ************************
    logic scanWindow;

    ptls_scan_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .PERIOD_TICKS(`PTLS_SCAN_PERIOD_MS),
        .ON_TICKS(`PTLS_SCAN_ON_MS)
    ) scanTimer (
        .clk(clk),
        .rstSyncB(rstSyncB),
        .msTick(),
        .scanWindow(scanWindow)
    );

    // ************************
    // Temperature sources
    // ************************
    logic [NSRC-1:0] srcOn;
    logic [NSRC-1:0] settled;
    logic detect;
    logic ocAny;
    logic shutdown;
    logic intHot;
    logic loadHigh;
    logic thermLow;

    assign loadHigh = state.syncB[`PTLS_PIN_LOAD];
    assign thermLow = state.syncB[`PTLS_PIN_THERM];
    assign intHot = state.syncB[`PTLS_PIN_IHOT];

    // Automatic pulse only while the scan is not switched off
    assign srcOn[PTLS_SRC_AUTO] = scanWindow
        && !state.ctrl[`PTLS_CTRL_SCANOFF];
    assign srcOn[PTLS_SRC_HOST] =
        (state.aoSel == `PTLS_AO_EXT_TEMP);
    assign srcOn[PTLS_SRC_FORCE] = state.ctrl[`PTLS_CTRL_FORCE];
    assign ocAny = chargeOvercurrentFlag || dischargeOvercurrentFlag
        || shortCircuitFlag;

    // Each requester owns its settle count, so one starting or stopping
    // never restarts the wait of another
    for (genvar s = 0; s < NSRC; s++) begin : gSettle
        assign settled[s] = srcOn[s]
            && state.settle[s] == SETTLE_W'(SETTLE_CYCLES);
    end
    assign detect = |settled;

    // The internal comparator carries its own hysteresis; the external
    // hot state only clears on a settled cool reading
    assign shutdown =
        (intHot && !state.ctrl[`PTLS_CTRL_INTDIS])
        || (state.extHot && !state.ctrl[`PTLS_CTRL_EXTDIS]);

    // ************************
    // Next state
    // ************************
    logic busTake;
    logic busHit;
    logic [31:0] rd;

    assign busTake = hsel && htrans[1] && hready;
    assign busHit = (haddr[31:`PTLS_ADDR_W] == 24'h0);

    always_comb begin
        next_state = state;
        rd = 32'h0;

        // Pin synchronisers
        next_state.syncA = {internalHot, thermistorBelowRef, loadSenseHigh};
        next_state.syncB = state.syncA;

        // Data phase writes
        if (state.phase == PTLS_PH_WRITE) begin
            case (state.addr)
                `PTLS_ADDR_CTRL: begin
                    next_state.ctrl = hwdata[`PTLS_CTRL_W-1:0];
                end
                `PTLS_ADDR_AOSEL: begin
                    // Selection stays writable during shutdown
                    next_state.aoSel = hwdata[`PTLS_AO_W-1:0];
                end
                `PTLS_ADDR_BAL: begin
                    if (!shutdown) begin
                        next_state.balance = hwdata[CELLS-1:0];
                    end
                end
                `PTLS_ADDR_STAT: begin
                    if (hwdata[`PTLS_STAT_INTOT]) begin
                        next_state.intFlag = 1'b0;
                    end
                    if (hwdata[`PTLS_STAT_EXTOT]) begin
                        next_state.extFlag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Switch bits drop and stay low while shut down
        if (shutdown) begin
            next_state.ctrl[`PTLS_CTRL_CHG] = 1'b0;
            next_state.ctrl[`PTLS_CTRL_DSG] = 1'b0;
        end

        // Load monitor status follows the comparator while enabled
        next_state.loadFlag = state.ctrl[`PTLS_CTRL_LOADWATCH]
            && loadHigh;

        // Settle counts run from the cycle the supply is really on
        for (int s = 0; s < NSRC; s++) begin
            if (!(srcOn[s] && state.supply)) begin
                next_state.settle[s] = '0;
            end else if (!settled[s]) begin
                next_state.settle[s] = state.settle[s] + SETTLE_W'(1);
            end
        end

        // Compare only after the divider has settled
        if (detect) begin
            next_state.extHot = thermLow;
        end

        // Hardware set beats a software clear in the same cycle
        if (intHot) begin
            next_state.intFlag = 1'b1;
        end
        if (detect && thermLow) begin
            next_state.extFlag = 1'b1;
        end

        next_state.supply = (|srcOn) || ocAny;
        next_state.chargeOut = next_state.ctrl[`PTLS_CTRL_CHG] && !shutdown;
        next_state.dischargeOut = next_state.ctrl[`PTLS_CTRL_DSG]
            && !shutdown;
        next_state.balanceOut = shutdown ? '0
            : next_state.balance;

        // Address phase; read data taken from the updated values so
        // a read right after a write sees the new contents
        if (hready) begin
            next_state.phase = PTLS_PH_IDLE;
            if (busTake && busHit) begin
                next_state.phase = hwrite ? PTLS_PH_WRITE : PTLS_PH_READ;
                next_state.addr = haddr[`PTLS_ADDR_W-1:0];
            end
            if (busTake && !hwrite && busHit) begin
                case (haddr[`PTLS_ADDR_W-1:0])
                    `PTLS_ADDR_CTRL: begin
                        rd[`PTLS_CTRL_W-1:0] = next_state.ctrl;
                    end
                    `PTLS_ADDR_AOSEL: begin
                        rd[`PTLS_AO_W-1:0] = next_state.aoSel;
                    end
                    `PTLS_ADDR_BAL: begin
                        rd[CELLS-1:0] = next_state.balance;
                    end
                    `PTLS_ADDR_STAT: begin
                        rd[`PTLS_STAT_LOAD] = next_state.loadFlag;
                        rd[`PTLS_STAT_INTOT] = next_state.intFlag;
                        rd[`PTLS_STAT_EXTOT] = next_state.extFlag;
                        rd[`PTLS_STAT_SUPPLY] = next_state.supply;
                        rd[`PTLS_STAT_SHUT] = shutdown;
                        rd[`PTLS_STAT_EXTHOT] = next_state.extHot;
                        rd[`PTLS_STAT_INTHOT] = intHot;
                    end
                    default: begin
                        rd = 32'h0;
                    end
                endcase
                next_state.rdata = rd;
            end
        end
    end

    // ************************
    // State register
    // ************************
    always_ff @(posedge clk or negedge rstSyncB) begin
        if (!rstSyncB) begin
            state <= '{syncA: 3'h0, syncB: 3'h0, ctrl: `PTLS_CTRL_RESET,
                       aoSel: `PTLS_AO_RESET, balance: '0,
                       loadFlag: 1'b0, intFlag: 1'b0, extFlag: 1'b0,
                       extHot: 1'b0, settle: '0, supply: 1'b0,
                       chargeOut: 1'b0, dischargeOut: 1'b0,
                       balanceOut: '0, phase: PTLS_PH_IDLE,
                       addr: '0, rdata: 32'h0};
        end else begin
            state <= next_state;
        end
    end

    // ************************
    // Outputs
    // ************************
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state.rdata;
    // Drives the internal pull-down on the load sense pin
    assign loadWatchEnable = state.ctrl[`PTLS_CTRL_LOADWATCH];
    assign thermistorSupplyOut = state.supply;
    assign chargeSwitchCtrl = state.chargeOut;
    assign dischargeSwitchCtrl = state.dischargeOut;
    assign balanceSwitch = state.balanceOut;
    assign analogOutSelect = state.aoSel;
    assign loadStillPresentFlag = state.loadFlag;
    assign internalOvertempFlag = state.intFlag;
    assign externalOvertempFlag = state.extFlag;

    // ************************
    // Checks
    // ************************
    logic wrCtrl;
    logic wrAo;

    assign wrCtrl = state.phase == PTLS_PH_WRITE
        && state.addr == `PTLS_ADDR_CTRL;
    assign wrAo = state.phase == PTLS_PH_WRITE
        && state.addr == `PTLS_ADDR_AOSEL;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSyncB);

    watch_write_a: assert property (
        wrCtrl |=> loadWatchEnable
            == $past(hwdata[`PTLS_CTRL_LOADWATCH]))
        else $error("load watch enable did not follow write");
    load_idle_a: assert property (
        !loadWatchEnable |=> !loadStillPresentFlag)
        else $error("load flag set while monitor off");
    load_release_a: assert property (
        loadStillPresentFlag && !loadHigh |=> !loadStillPresentFlag)
        else $error("load flag kept after release");
    scan_pulse_a: assert property (
        srcOn[PTLS_SRC_AUTO] |=> thermistorSupplyOut)
        else $error("auto scan pulse missing");
    scan_off_a: assert property (
        state.ctrl[`PTLS_CTRL_SCANOFF] && !srcOn[PTLS_SRC_HOST]
            && !srcOn[PTLS_SRC_FORCE] && !ocAny |=> !thermistorSupplyOut)
        else $error("supply on while scan disabled");
    settle_wait_a: assert property (
        $rose(thermistorSupplyOut) |-> !detect ##1 $stable(state.extHot))
        else $error("compare before settle time");
    host_scan_a: assert property (
        srcOn[PTLS_SRC_HOST] |=> thermistorSupplyOut)
        else $error("host temperature select left supply off");
    // Two held cycles of the bit, as a write may clear it after one
    force_on_a: assert property (
        state.ctrl[`PTLS_CTRL_FORCE] ##1 state.ctrl[`PTLS_CTRL_FORCE]
            |-> thermistorSupplyOut[*2])
        else $error("force on did not hold supply");
    oc_wake_a: assert property (
        ocAny |=> thermistorSupplyOut)
        else $error("overcurrent flag did not raise supply");
    shut_off_a: assert property (
        shutdown |=> !chargeSwitchCtrl && !dischargeSwitchCtrl
            && balanceSwitch == '0)
        else $error("switches on during shutdown");
    int_flag_a: assert property (
        intHot |=> internalOvertempFlag)
        else $error("internal overtemp flag not set");
    shut_ignore_a: assert property (
        shutdown && wrCtrl |=> !state.ctrl[`PTLS_CTRL_CHG]
            && !state.ctrl[`PTLS_CTRL_DSG])
        else $error("switch write taken during shutdown");
    ao_accept_a: assert property (
        wrAo |=> analogOutSelect == $past(hwdata[`PTLS_AO_W-1:0]))
        else $error("analog select write lost");
    int_disable_a: assert property (
        state.ctrl[`PTLS_CTRL_INTDIS] && !state.extHot && !wrCtrl
            && state.ctrl[`PTLS_CTRL_CHG] |=> chargeSwitchCtrl)
        else $error("internal shutdown while disabled");
    ext_disable_a: assert property (
        state.ctrl[`PTLS_CTRL_EXTDIS] && !intHot && !wrCtrl
            && state.ctrl[`PTLS_CTRL_DSG] |=> dischargeSwitchCtrl)
        else $error("external shutdown while disabled");
endmodule
`default_nettype wire

// ---- verification/ptls_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ptls_host_model (
    // Bus clock and slave answer
    input wire logic clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    // Master request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    // ************************
    // Single word transfer
    // ************************
    // Call just after a rising edge; returns at the edge that ends the
    // data phase, so calls may follow back to back.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
        // Released data lines must not keep looking valid
        hwdata <= ~wd;
    endtask
endmodule
`default_nettype wire

// ---- verification/ptls_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module ptls_tb_top;
    import ptls_pkg::*;
    localparam int unsigned TICK = 20;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic loadSense = 1'b0;
    logic therm = 1'b0;
    logic intHot = 1'b0;
    logic [2:0] oc = 3'h0;
    logic loadWatchEnable, thermistorSupplyOut;
    logic chargeSwitchCtrl, dischargeSwitchCtrl;
    logic [5:0] balanceSwitch;
    logic [3:0] analogOutSelect;
    logic loadStillPresentFlag, internalOvertempFlag, externalOvertempFlag;
    int mismatches = 0;
    int check_count = 0;

    initial begin
        forever #2.5 clk = ~clk;
    end

    ptls_top #(.TICK_CYCLES(TICK), .CELLS(6)) ptls_top_inst (
        .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .loadSenseHigh(loadSense),
        .thermistorBelowRef(therm), .internalHot(intHot),
        .chargeOvercurrentFlag(oc[0]), .dischargeOvercurrentFlag(oc[1]),
        .shortCircuitFlag(oc[2]), .loadWatchEnable(loadWatchEnable),
        .thermistorSupplyOut(thermistorSupplyOut),
        .chargeSwitchCtrl(chargeSwitchCtrl),
        .dischargeSwitchCtrl(dischargeSwitchCtrl),
        .balanceSwitch(balanceSwitch), .analogOutSelect(analogOutSelect),
        .loadStillPresentFlag(loadStillPresentFlag),
        .internalOvertempFlag(internalOvertempFlag),
        .externalOvertempFlag(externalOvertempFlag));

    ptls_host_model ptls_host_model_inst (
        .clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    // ************************
    // Helpers
    // ************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        ptls_host_model_inst.xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        ptls_host_model_inst.xfer(1'b0, a, 32'h0, d);
    endtask
    task automatic st(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ************************
    // Scenarios
    // ************************
    task automatic t_reset;
        logic [31:0] d;
        chk1(loadWatchEnable, 1'b0);
        for (int a = 0; a < 12; a += 4) begin
            rd(a[7:0], d);
            chk(d, 32'h0);
        end
        rd(8'h10, d);
        chk(d, 32'h0);
        chk1(hresp, 1'b0);
        wr(8'h04, 32'h5);
        st(2);
        chk({28'h0, analogOutSelect}, 32'h5);
        $display("reset test done");
    endtask

    task automatic t_scan;
        int n;
        n = 0;
        while (thermistorSupplyOut === 1'b1 && n < 20000) begin
            st(1);
            n++;
        end
        n = 0;
        while (thermistorSupplyOut !== 1'b1 && n < 20000) begin
            st(1);
            n++;
        end
        chk(n, (640 - 5) * TICK);
        n = 0;
        while (thermistorSupplyOut === 1'b1 && n < 20000) begin
            st(1);
            n++;
        end
        chk(n, 5 * TICK);
        $display("scan test done");
    endtask

    task automatic t_force;
        int n;
        wr(8'h00, 32'h6);
        st(2);
        chk1(thermistorSupplyOut, 1'b1);
        st(300);
        chk1(thermistorSupplyOut, 1'b1);
        wr(8'h00, 32'h2);
        n = 0;
        for (int i = 0; i < 13000; i++) begin
            st(1);
            n += int'(thermistorSupplyOut === 1'b1);
        end
        chk(n, 0);
        $display("force test done");
    endtask

    task automatic t_load;
        for (int i = 0; i < 3; i++) begin
            oc <= 3'h1 << i;
            st(3);
            chk1(thermistorSupplyOut, 1'b1);
        end
        wr(8'h00, 32'h3);
        st(2);
        chk1(loadWatchEnable, 1'b1);
        loadSense <= 1'b1;
        st(6);
        chk1(loadStillPresentFlag, 1'b1);
        loadSense <= 1'b0;
        st(6);
        chk1(loadStillPresentFlag, 1'b0);
        oc <= 3'h0;
        wr(8'h00, 32'h2);
        st(3);
        chk1(thermistorSupplyOut, 1'b0);
        $display("load test done");
    endtask

    task automatic t_ext;
        logic [31:0] d;
        wr(8'h00, 32'h62);
        wr(8'h08, 32'h3f);
        st(2);
        chk({30'h0, chargeSwitchCtrl, dischargeSwitchCtrl}, 32'h3);
        chk({26'h0, balanceSwitch}, 32'h3f);
        therm <= 1'b1;
        wr(8'h04, 32'h8);
        st(2);
        chk1(thermistorSupplyOut, 1'b1);
        chk({28'h0, analogOutSelect}, 32'h8);
        st(10);
        chk1(externalOvertempFlag, 1'b0);
        st(30);
        chk1(externalOvertempFlag, 1'b1);
        chk({30'h0, chargeSwitchCtrl, dischargeSwitchCtrl}, 32'h0);
        chk({26'h0, balanceSwitch}, 32'h0);
        wr(8'h00, 32'h62);
        wr(8'h08, 32'h01);
        wr(8'h04, 32'h9);
        st(2);
        chk1(chargeSwitchCtrl, 1'b0);
        chk({28'h0, analogOutSelect}, 32'h9);
        rd(8'h00, d);
        chk(d, 32'h2);
        st(100);
        chk1(dischargeSwitchCtrl, 1'b0);
        therm <= 1'b0;
        wr(8'h04, 32'h8);
        st(40);
        wr(8'h00, 32'h62);
        st(2);
        chk1(chargeSwitchCtrl, 1'b1);
        chk({26'h0, balanceSwitch}, 32'h3f);
        wr(8'h0c, 32'h4);
        rd(8'h0c, d);
        chk(d & 32'h4, 32'h0);
        $display("external test done");
    endtask

    task automatic t_disable;
        logic [31:0] d;
        wr(8'h00, 32'h6a);
        intHot <= 1'b1;
        st(6);
        chk1(chargeSwitchCtrl, 1'b1);
        chk1(internalOvertempFlag, 1'b1);
        wr(8'h00, 32'h62);
        st(4);
        chk1(chargeSwitchCtrl, 1'b0);
        intHot <= 1'b0;
        st(6);
        wr(8'h00, 32'h72);
        therm <= 1'b1;
        st(40);
        chk1(dischargeSwitchCtrl, 1'b1);
        rd(8'h0c, d);
        chk(d & 32'h20, 32'h20);
        therm <= 1'b0;
        st(40);
        $display("disable test done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        st(3);
        t_reset();
        t_scan();
        t_force();
        t_load();
        t_ext();
        t_disable();
        results();
    end

    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        $display("watchdog expired");
        results();
    end
endmodule
`default_nettype wire
